// [hw/oss_pkg.sv]
// Package with register map, reset values, timing constants and carrier types of the output sync supervisor.
package oss_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] IDX_MODE_SELECT = 8'h01;
    localparam logic [7:0] IDX_CYCLE_PERIOD = 8'h02;
    localparam logic [7:0] IDX_PULSE0_DELAY = 8'h03;
    localparam logic [7:0] IDX_CAPABILITY = 8'h04;
    localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
    localparam logic [7:0] IDX_MIN_SPACING = 8'h06;
    localparam logic [7:0] IDX_MIN_DELAY = 8'h07;
    localparam logic [7:0] IDX_MEASURE_CTRL = 8'h08;
    localparam logic [7:0] IDX_PULSE1_DELAY = 8'h09;
    localparam logic [7:0] IDX_MISSED_COUNT = 8'h0b;
    localparam logic [7:0] IDX_OVERRUN_COUNT = 8'h0c;
    localparam logic [7:0] IDX_SHORT_COUNT = 8'h0d;
    localparam logic [7:0] IDX_LATE_FLAG = 8'h20;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam logic [7:0] IDX_MEASURED_CYCLE = 8'h32;
    localparam logic [9:0] ADDR_MAX = 10'h0ff;

    // Reset values.
    localparam logic [7:0] RST_ENTRY_COUNT = 8'h20;
    localparam logic [15:0] RST_MODE_SELECT = 16'h0001;
    localparam logic [31:0] RST_CYCLE_PERIOD = 32'h000f4240;
    localparam logic [31:0] RST_PULSE0_DELAY = 32'h00000000;
    localparam logic [15:0] RST_CAPABILITY = 16'hc007;
    localparam logic [31:0] RST_MIN_CYCLE = 32'h0003d090;
    localparam logic [31:0] RST_MIN_SPACING = 32'h00000000;
    localparam logic [31:0] RST_MIN_DELAY = 32'h00000000;
    localparam logic [31:0] RST_PULSE1_DELAY = 32'h00000000;

    // Mode encodings.
    localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] MODE_BUF_EVENT = 16'h0001;
    localparam logic [15:0] MODE_DC_PULSE0 = 16'h0002;
    localparam logic [15:0] MODE_DC_PULSE1 = 16'h0003;

    // Interrupt status bit positions.
    localparam int IRQ_MISSED = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SHORT = 2;
    localparam int IRQ_LATE = 3;
    localparam int IRQ_WIDTH = 4;

    // Timing: clock period and the nanoseconds added per clock.
    localparam int CLOCK_PERIOD_NS = 25;
    localparam logic [31:0] NS_PER_TICK = 32'h00000019;

    // Event pulses after synchronisation and edge detection.
    typedef struct packed {
        logic buf_event;
        logic pulse0;
        logic pulse1;
        logic output_done;
    } oss_events_t;
endpackage : oss_pkg

// [hw/oss_pin_sync.sv]
// Two-flop synchroniser with rising-edge pulse for the asynchronous event pins.
`timescale 1ns/1ps
`default_nettype none
module oss_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] rise_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] last;
    } oss_sync_state_t;

    oss_sync_state_t state_ff;
    oss_sync_state_t nxt_state;

    // Only the second stage and its delayed copy feed the edge detector.
    always_comb
    begin
        nxt_state.meta = pin_in;
        nxt_state.stable = state_ff.meta;
        nxt_state.last = state_ff.stable;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign rise_out = state_ff.stable & ~state_ff.last;
endmodule : oss_pin_sync
`default_nettype wire

// [hw/oss_output_sync.sv]
// Output synchronisation supervisor: mode select, cycle timing, event counters and register port.
// Operation
// - Mode 0 free, 1 buffer, 2/3 pulses.
// - Mode resets to buffer event.
// - Cycle time in ns; free-run timer period.
// - Buffer mode: cycle is master bus cycle.
// - DC mode: cycle is pulse period.
// - Pulse0-to-output delay reported, read-only.
// - Capability word reads fixed value.
// - Minimum cycle time reads 250000 ns.
// - Minimum pulse spacing reported, read-only.
// - Command 1 starts, 0 stops measurement.
// - Pulse1-to-output delay reported, read-only.
// - Missed buffer events counted in run, DC.
// - Overruns counted while in run state.
// - Too-short pulse spacing counted in DC.
// - Late flag set late, cleared when correct, in DC only.
// - Buffer channel event triggers buffer sync.
`timescale 1ns/1ps
`default_nettype none
module oss_output_sync #(
    parameter logic [31:0] MIN_CYCLE_NS = oss_pkg::RST_MIN_CYCLE,
    parameter logic [31:0] MIN_SPACING_NS = oss_pkg::RST_MIN_SPACING
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic RUN_STATE,
    input wire logic OUTPUT_BUFFER_EVENT,
    input wire logic DC_SYNC_PULSE_0,
    input wire logic DC_SYNC_PULSE_1,
    input wire logic OUTPUT_DONE,
    output logic APPLY_OUTPUTS,
    output logic IRQ
);
    // Elaboration check: a minimum cycle shorter than one clock could never be timed.
    if (MIN_CYCLE_NS < oss_pkg::NS_PER_TICK)
    begin : g_min_cycle_check
        $error("Minimum cycle time below one clock period.");
    end

    typedef struct packed {
        logic [15:0] mode;
        logic [31:0] cycle;
        logic measuring;
        logic [31:0] timer_ns;
        logic [31:0] measured;
        logic [31:0] since_p0;
        logic [31:0] since_p1;
        logic [31:0] p0_delay;
        logic [31:0] p1_delay;
        logic [31:0] since_event;
        logic pending;
        logic busy;
        logic [15:0] missed;
        logic [15:0] overrun;
        logic [15:0] short_cnt;
        logic late;
        logic [oss_pkg::IRQ_WIDTH-1:0] status;
        logic [oss_pkg::IRQ_WIDTH-1:0] mask;
        logic apply;
        logic [31:0] rdata;
    } oss_state_t;

    oss_state_t st_ff;
    oss_state_t nxt_st;
    oss_pkg::oss_events_t ev;
    logic [3:0] ev_rise;

    // Saturating increment for the 16-bit event counters.
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : sat_inc

    // Saturating nanosecond accumulator.
    function automatic logic [31:0] ns_add(input logic [31:0] v);
        ns_add = (v > 32'hffffffff - oss_pkg::NS_PER_TICK) ? 32'hffffffff : v + oss_pkg::NS_PER_TICK;
    endfunction : ns_add

    // The event pins come from outside this clock, so they are synchronised first.
    oss_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .pin_in({OUTPUT_BUFFER_EVENT, DC_SYNC_PULSE_0, DC_SYNC_PULSE_1, OUTPUT_DONE}),
        .rise_out(ev_rise)
    );
    assign ev = ev_rise;

    logic dc_mode;
    logic trigger;
    logic free_tick;
    logic [oss_pkg::IRQ_WIDTH-1:0] ev_irq;

    // Mode decode and selection of the trigger that applies outputs.
    always_comb
    begin
        dc_mode = (st_ff.mode == oss_pkg::MODE_DC_PULSE0) || (st_ff.mode == oss_pkg::MODE_DC_PULSE1);
        // The tick is taken one clock early so that the period is cycle/25 clocks, not one more.
        free_tick = (ns_add(st_ff.timer_ns) >= st_ff.cycle);
        unique case (st_ff.mode)
            oss_pkg::MODE_FREE_RUN: trigger = free_tick;
            oss_pkg::MODE_BUF_EVENT: trigger = ev.buf_event;
            oss_pkg::MODE_DC_PULSE0: trigger = ev.pulse0;
            oss_pkg::MODE_DC_PULSE1: trigger = ev.pulse1;
            default: trigger = 1'b0;
        endcase
    end

    // Next-state logic: timing, counters, registers and interrupts.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.apply = trigger;
        ev_irq = '0;
        // Free-run local timer restarts on each tick in free-run mode; other triggers do not restart it.
        nxt_st.timer_ns = (st_ff.mode == oss_pkg::MODE_FREE_RUN && free_tick) ? 32'h0 : ns_add(st_ff.timer_ns);
        nxt_st.since_p0 = ev.pulse0 ? 32'h0 : ns_add(st_ff.since_p0);
        nxt_st.since_p1 = ev.pulse1 ? 32'h0 : ns_add(st_ff.since_p1);
        nxt_st.since_event = trigger ? 32'h0 : ns_add(st_ff.since_event);
        // Intervals include the current clock, so one tick is added to the registered count.
        if (trigger && st_ff.measuring)
            nxt_st.measured = ns_add(st_ff.since_event);
        // Output delays are measured only in DC mode and only while measuring.
        if (ev.output_done && dc_mode && st_ff.measuring)
        begin
            nxt_st.p0_delay = ns_add(st_ff.since_p0);
            nxt_st.p1_delay = ns_add(st_ff.since_p1);
        end
        // Pulse spacing check; the spacing is taken from pulse0 to pulse1.
        if (ev.pulse1 && dc_mode)
        begin
            if (ns_add(st_ff.since_p0) < MIN_SPACING_NS)
            begin
                nxt_st.short_cnt = sat_inc(st_ff.short_cnt);
                ev_irq[oss_pkg::IRQ_SHORT] = 1'b1;
            end
        end
        // Missed buffer event: a DC trigger arrived with no buffer event since the last one.
        if (ev.buf_event)
            nxt_st.pending = 1'b1;
        if (trigger)
        begin
            if (dc_mode && RUN_STATE && !st_ff.pending && !ev.buf_event)
            begin
                nxt_st.missed = sat_inc(st_ff.missed);
                ev_irq[oss_pkg::IRQ_MISSED] = 1'b1;
            end
            nxt_st.pending = 1'b0;
            // A new cycle starting while the last is unfinished is an overrun.
            if (RUN_STATE && st_ff.busy && !ev.output_done)
            begin
                nxt_st.overrun = sat_inc(st_ff.overrun);
                ev_irq[oss_pkg::IRQ_OVERRUN] = 1'b1;
            end
            nxt_st.busy = 1'b1;
        end
        else if (ev.output_done)
            nxt_st.busy = 1'b0;
        // Late flag reflects the most recent cycle only.
        if (ev.output_done && dc_mode)
        begin
            nxt_st.late = (ns_add(st_ff.since_event) > st_ff.cycle);
            ev_irq[oss_pkg::IRQ_LATE] = (ns_add(st_ff.since_event) > st_ff.cycle);
        end
        // Register writes; read-only registers ignore writes.
        if (REG_WR)
        begin
            unique case (REG_ADDR)
                oss_pkg::IDX_MODE_SELECT: nxt_st.mode = REG_WDATA[15:0];
                oss_pkg::IDX_CYCLE_PERIOD: nxt_st.cycle = REG_WDATA;
                oss_pkg::IDX_MEASURE_CTRL: nxt_st.measuring = (REG_WDATA[15:0] == 16'h0001);
                oss_pkg::IDX_IRQ_MASK: nxt_st.mask = REG_WDATA[oss_pkg::IRQ_WIDTH-1:0];
                oss_pkg::IDX_IRQ_STATUS: nxt_st.status = st_ff.status & ~REG_WDATA[oss_pkg::IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        // Set wins over a write-one clear in the same cycle.
        nxt_st.status = nxt_st.status | ev_irq;
        // Read data stand the cycle after the strobe only.
        nxt_st.rdata = 32'h0;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                oss_pkg::IDX_ENTRY_COUNT: nxt_st.rdata = {24'h0, oss_pkg::RST_ENTRY_COUNT};
                oss_pkg::IDX_MODE_SELECT: nxt_st.rdata = {16'h0, st_ff.mode};
                oss_pkg::IDX_CYCLE_PERIOD: nxt_st.rdata = st_ff.cycle;
                oss_pkg::IDX_PULSE0_DELAY: nxt_st.rdata = st_ff.p0_delay;
                oss_pkg::IDX_CAPABILITY: nxt_st.rdata = {16'h0, oss_pkg::RST_CAPABILITY};
                oss_pkg::IDX_MIN_CYCLE: nxt_st.rdata = MIN_CYCLE_NS;
                oss_pkg::IDX_MIN_SPACING: nxt_st.rdata = MIN_SPACING_NS;
                oss_pkg::IDX_MIN_DELAY: nxt_st.rdata = oss_pkg::RST_MIN_DELAY;
                oss_pkg::IDX_MEASURE_CTRL: nxt_st.rdata = {31'h0, st_ff.measuring};
                oss_pkg::IDX_PULSE1_DELAY: nxt_st.rdata = st_ff.p1_delay;
                oss_pkg::IDX_MISSED_COUNT: nxt_st.rdata = {16'h0, st_ff.missed};
                oss_pkg::IDX_OVERRUN_COUNT: nxt_st.rdata = {16'h0, st_ff.overrun};
                oss_pkg::IDX_SHORT_COUNT: nxt_st.rdata = {16'h0, st_ff.short_cnt};
                oss_pkg::IDX_LATE_FLAG: nxt_st.rdata = {31'h0, st_ff.late};
                oss_pkg::IDX_IRQ_STATUS: nxt_st.rdata = {28'h0, st_ff.status};
                oss_pkg::IDX_IRQ_MASK: nxt_st.rdata = {28'h0, st_ff.mask};
                oss_pkg::IDX_MEASURED_CYCLE: nxt_st.rdata = st_ff.measured;
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    // State register; every field has a defined reset value.
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            st_ff <= '0;
            st_ff.mode <= oss_pkg::RST_MODE_SELECT;
            st_ff.cycle <= oss_pkg::RST_CYCLE_PERIOD;
            st_ff.p0_delay <= oss_pkg::RST_PULSE0_DELAY;
            st_ff.p1_delay <= oss_pkg::RST_PULSE1_DELAY;
        end
        else
            st_ff <= nxt_st;
    end

    assign REG_RDATA = st_ff.rdata;
    assign APPLY_OUTPUTS = st_ff.apply;
    assign IRQ = |(st_ff.status & st_ff.mask);

    // Assertions.
    sequence s_overrun_cause;
        trigger && RUN_STATE && st_ff.busy && !ev.output_done;
    endsequence

    a_mode_reset: assert property (@(posedge CLOCK) $rose(RSTN) |-> st_ff.mode == 16'h0001)
        else $error("Mode not at buffer event after reset.");
    a_buf_trigger: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (st_ff.mode == 16'h0001 && ev.buf_event) |=> APPLY_OUTPUTS)
        else $error("Buffer event did not apply outputs.");
    a_free_period: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (st_ff.mode == 16'h0000 && !REG_WR && {1'b0, st_ff.timer_ns} + 33'h019 >= {1'b0, st_ff.cycle})
        |=> st_ff.timer_ns == 32'h0)
        else $error("Free-run timer not restarted at cycle end.");
    a_capability_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (REG_RD && REG_ADDR == 8'h04) |=> REG_RDATA == 32'h0000c007)
        else $error("Capability word wrong.");
    a_min_cycle_read: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (REG_RD && REG_ADDR == 8'h05) |=> REG_RDATA == MIN_CYCLE_NS)
        else $error("Minimum cycle time wrong.");
    a_measure_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (REG_WR && REG_ADDR == 8'h08) |=> st_ff.measuring == ($past(REG_WDATA[15:0]) == 16'h0001))
        else $error("Measurement command not taken.");
    a_overrun_count: assert property (@(posedge CLOCK) disable iff (!RSTN)
        s_overrun_cause |=> (st_ff.overrun == $past(st_ff.overrun) + 16'h0001) || (st_ff.overrun == 16'hffff))
        else $error("Overrun not counted.");
    a_missed_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !dc_mode |=> st_ff.missed == $past(st_ff.missed))
        else $error("Missed counter moved outside DC mode.");
    a_short_sat: assert property (@(posedge CLOCK) disable iff (!RSTN)
        st_ff.short_cnt == 16'hffff |=> st_ff.short_cnt == 16'hffff)
        else $error("Short spacing counter wrapped.");
    a_late_flag: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (ev.output_done && dc_mode && {1'b0, st_ff.since_event} + 33'h019 <= {1'b0, st_ff.cycle})
        |=> !st_ff.late)
        else $error("Late flag not cleared on a correct cycle.");
    a_irq_level: assert property (@(posedge CLOCK) disable iff (!RSTN)
        ((st_ff.status & st_ff.mask) != 4'h0) |-> IRQ)
        else $error("Interrupt not raised.");
    // An event sets its status bit even when software clears it in the same cycle.
    a_status_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (ev_irq != 4'h0) |=> ((st_ff.status & $past(ev_irq)) == $past(ev_irq)))
        else $error("Event did not set its status bit.");
endmodule : oss_output_sync
`default_nettype wire

// [tb/oss_master_model.sv]
// Partner model: the fieldbus master side that drives the event pins of the supervisor.
`timescale 1ns/1ps
`default_nettype none
module oss_master_model (
    input wire logic clk,
    output logic [3:0] pins
);
    // Pin 0 is the buffer event, 1 pulse 0, 2 pulse 1, 3 outputs driven; all idle low.
    initial pins = 4'h0;

    // Pulses are three clocks wide, since the two-flop synchroniser may drop anything shorter.
    task automatic pulse(input int i);
        @(posedge clk);
        pins[i] <= 1'b1;
        repeat (3) @(posedge clk);
        pins[i] <= 1'b0;
    endtask : pulse
endmodule : oss_master_model
`default_nettype wire

// [tb/oss_output_sync_test.sv]
// Self-checking testbench of the output sync supervisor.
`timescale 1ns/1ps
`default_nettype none
module oss_output_sync_test;
    localparam logic [31:0] SPC_NS = 32'h000001f4;
    localparam logic [7:0] RI [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20, 8'h30, 8'h31, 8'h0a};
    localparam logic [31:0] RV [17] = '{32'h20, 32'h1, 32'hf4240, 32'h0, 32'hc007, 32'h3d090, SPC_NS,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic pend = 1'b0;
    logic [31:0] rdata;
    logic [3:0] pins;
    logic apply;
    logic irq;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'hc;
    int bad_count = 0;
    int num_checks = 0;
    int napply = 0;

    // Half period of the 40 MHz clock.
    always #12.5 clk = ~clk;

    oss_output_sync #(.MIN_SPACING_NS(SPC_NS)) dut_u (.CLOCK(clk), .RSTN(rstn), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RUN_STATE(run),
        .OUTPUT_BUFFER_EVENT(pins[0]), .DC_SYNC_PULSE_0(pins[1]), .DC_SYNC_PULSE_1(pins[2]),
        .OUTPUT_DONE(pins[3]), .APPLY_OUTPUTS(apply), .IRQ(irq));
    oss_master_model m_u (.clk(clk), .pins(pins));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle.
    always @(posedge clk) pend <= rd;
    always @(negedge clk)
    begin
        if (apply === 1'b1)
            napply++;
        if (pend === 1'b1)
            check(rdata, exp_q.pop_front(), "read data");
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask : gap

    // A mid-run reset gives the overrun and missed scenarios a known starting state.
    task automatic rst_dut();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask : rst_dut

    task automatic results();
        for (int k = 0; k < 20 && exp_q.size() > 0; k++)
            @(posedge clk);
        if (exp_q.size() > 0)
        begin
            bad_count++;
            $display("MISMATCH at %0t: read data never arrived", $time);
        end
        $display("Counts: %0d checks, %0d mismatches", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, then random writes to every read-only place but IDX_MEASURED_CYCLE, which must change nothing.
        for (int k = 0; k < 17; k++)
            rd_reg(RI[k], RV[k]);
        for (int k = 0; k < 17; k++)
        begin
            seed = xs(seed);
            if (!(RI[k] inside {8'h01, 8'h02, 8'h08, 8'h31}))
                wr_reg(RI[k], seed);
        end
        for (int k = 0; k < 17; k++)
            rd_reg(RI[k], RV[k]);
        seed = xs(seed);
        wr_reg(8'h02, seed);
        rd_reg(8'h02, seed);
        $display("Test registers done");
        // Free run with a 1000 ns period gives one apply every 40 clocks; the first, immediate one is skipped.
        wr_reg(8'h02, 32'h3e8);
        wr_reg(8'h01, 32'h0);
        gap(2);
        napply = 0;
        gap(400);
        check(napply, 32'ha, "free run rate");
        // Each synchronised mode applies outputs on its own event only.
        for (int m = 1; m < 4; m++)
        begin
            wr_reg(8'h01, m);
            rd_reg(8'h01, m);
            for (int i = 0; i < 3; i++)
            begin
                napply = 0;
                m_u.pulse(i);
                gap(8);
                check(napply, (i == m - 1), "apply count");
            end
        end
        $display("Test modes done");
        // Two buffer events with no outputs driven between them make one overrun.
        rst_dut();
        run <= 1'b1;
        m_u.pulse(0);
        m_u.pulse(0);
        gap(8);
        rd_reg(8'h0c, 32'h1);
        rd_reg(8'h0b, 32'h0);
        rd_reg(8'h30, 32'h2);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr_reg(8'h31, 32'h2);
        gap(1);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        wr_reg(8'h30, 32'h2);
        gap(1);
        check({31'h0, irq}, 32'h0, "cleared irq");
        rd_reg(8'h30, 32'h0);
        $display("Test overrun done");
        // In pulse 0 mode a second pulse with no buffer event in between is a missed event.
        rst_dut();
        run <= 1'b1;
        wr_reg(8'h01, 32'h2);
        m_u.pulse(0);
        m_u.pulse(1);
        m_u.pulse(3);
        m_u.pulse(1);
        m_u.pulse(3);
        gap(8);
        rd_reg(8'h0b, 32'h1);
        rd_reg(8'h0c, 32'h0);
        $display("Test missed done");
        // Outputs driven 1500 ns after the trigger are late, 200 ns after are in time.
        wr_reg(8'h02, 32'h3e8);
        m_u.pulse(1);
        gap(56);
        m_u.pulse(3);
        gap(8);
        rd_reg(8'h20, 32'h1);
        rd_reg(8'h30, 32'h9);
        m_u.pulse(1);
        gap(4);
        m_u.pulse(3);
        gap(8);
        rd_reg(8'h20, 32'h0);
        $display("Test late done");
        // Measuring: 20 clocks from pulse 0 to outputs driven reads as 500 ns.
        wr_reg(8'h08, 32'h1);
        rd_reg(8'h08, 32'h1);
        m_u.pulse(1);
        gap(16);
        m_u.pulse(3);
        gap(8);
        rd_reg(8'h03, 32'h1f4);
        // The next pulse 0 comes 34 clocks after the last, so the measured cycle is 850 ns.
        m_u.pulse(1);
        gap(8);
        rd_reg(8'h32, 32'h352);
        wr_reg(8'h08, 32'h5);
        rd_reg(8'h08, 32'h0);
        $display("Test measure done");
        // Pulse 1 at 100 ns after pulse 0 is too close; at 850 ns it is not.
        m_u.pulse(1);
        m_u.pulse(2);
        gap(8);
        rd_reg(8'h0d, 32'h1);
        m_u.pulse(1);
        gap(30);
        m_u.pulse(2);
        gap(8);
        rd_reg(8'h0d, 32'h1);
        $display("Test spacing done");
        results();
    end
endmodule : oss_output_sync_test
`default_nettype wire
